/* File: design/t1_maint_pkg.sv */
// Package of register map, field layout and constants for the T1 maintenance block
package t1_maint_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SECOND_STATUS = 8'h21;
    localparam logic [7:0] OFF_BPV_HIGH = 8'h23;
    localparam logic [7:0] OFF_BPV_LOW = 8'h24;
    localparam logic [7:0] OFF_CRC_HIGH = 8'h25;
    localparam logic [7:0] OFF_CRC_LOW = 8'h26;
    localparam logic [7:0] OFF_FBIT_ERR = 8'h27;
    localparam logic [7:0] OFF_DL_RX_BYTE = 8'h28;
    localparam logic [7:0] OFF_DL_MATCH_A = 8'h29;
    localparam logic [7:0] OFF_DL_MATCH_B = 8'h2a;
    localparam logic [7:0] OFF_COMMON_CTRL = 8'h2b;
    localparam logic [7:0] OFF_RX_CTRL = 8'h2c;
    localparam logic [7:0] OFF_SECOND_MASK = 8'h6f;
    localparam logic [7:0] OFF_DL_TX_BYTE = 8'h7e;
    // ------------------------------------------------------------
    // Status and mask bit positions
    // ------------------------------------------------------------
    localparam int ST_RX_MF = 7;
    localparam int ST_TX_MF = 6;
    localparam int ST_SECOND = 5;
    localparam int ST_RX_FULL = 4;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_MATCH = 2;
    localparam int ST_ABORT = 1;
    localparam int ST_LOSS_RX_CLK = 0;
    // ------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------
    localparam int CC_DESTUFF = 0;
    localparam int CC_B8ZS = 2;
    localparam int CC_EXT_SUPERFRAME = 3;
    localparam int CC_STUFF = 4;
    localparam int RC_ESF_EVENTS = 0;
    localparam int RC_SIG_FRAMING_ERR = 1;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_TX_BYTE = 8'hff;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [15:0] SAT16 = 16'hffff;
    localparam logic [7:0] SAT8 = 8'hff;
    localparam logic [3:0] STUFF_RUN = 4'h5;
    localparam logic [3:0] ABORT_RUN = 4'h8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // One-second timer in 125 us frames
    localparam int FRAME_US = 125;
    localparam int SEC_SHORT_MS = 999;
    localparam int SEC_LONG_MS = 1002;
    localparam int SEC_SHORT_FRAMES = SEC_SHORT_MS * 1000 / FRAME_US;
    localparam int SEC_LONG_FRAMES = SEC_LONG_MS * 1000 / FRAME_US;
    localparam logic [1:0] SEC_LAST_PHASE = 2'h2;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;
    typedef struct packed {
        logic sync_lost;
        logic bipolar_violation;
        logic b8zs_word;
        logic crc_err;
        logic fbit_err;
        logic sbit_err;
        logic mf_end;
        logic frame_tick;
        logic dl_valid;
        logic dl_bit;
        logic rx_clk_lost;
    } line_rx_t;
endpackage

/* File: design/t1_perf_counters_fdl_link.sv */
// Error counters, one-second timer and data link byte handling of a T1 framer
`timescale 1ns/10ps
module t1_perf_counters_fdl_link #(
    parameter int SEC_SHORT = t1_maint_pkg::SEC_SHORT_FRAMES,
    parameter int SEC_LONG = t1_maint_pkg::SEC_LONG_FRAMES,
    parameter int BUF_WIDTH = 1,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire t1_maint_pkg::host_req_t host_i,
    output logic [7:0] rdata_o,
    input wire t1_maint_pkg::line_rx_t line_i,
    input wire logic tx_mf_i,
    output logic [BUF_WIDTH-1:0] tx_bit_o,
    output logic tx_bit_valid_o,
    input wire logic tx_bit_ready_i,
    output logic second_interrupt_output_b_o
);
    import t1_maint_pkg::*;
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    logic [7:0] second_common_control;
    logic [7:0] second_receive_control;
    logic [7:0] second_interrupt_mask;
    logic [7:0] data_link_match_byte_a;
    logic [7:0] data_link_match_byte_b;
    logic [7:0] data_link_transmit_byte;
    logic [7:0] second_status_register;
    logic [7:0] clear_pending;
    logic [7:0] status_set;
    logic wr_hit_tx;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            second_common_control <= RST_BYTE;
            second_receive_control <= RST_BYTE;
            second_interrupt_mask <= RST_MASK;
            data_link_match_byte_a <= RST_BYTE;
            data_link_match_byte_b <= RST_BYTE;
            data_link_transmit_byte <= RST_TX_BYTE;
        end else if (host_i.wr) begin
            unique case (host_i.addr)
                OFF_COMMON_CTRL: second_common_control <= host_i.wdata;
                OFF_RX_CTRL: second_receive_control <= host_i.wdata;
                OFF_SECOND_MASK: second_interrupt_mask <= host_i.wdata;
                OFF_DL_MATCH_A: data_link_match_byte_a <= host_i.wdata;
                OFF_DL_MATCH_B: data_link_match_byte_b <= host_i.wdata;
                OFF_DL_TX_BYTE: data_link_transmit_byte <= host_i.wdata;
                default: ;
            endcase
        end
    end

    assign wr_hit_tx = host_i.wr && (host_i.addr == OFF_DL_TX_BYTE);
    logic esf_mode;
    assign esf_mode = second_common_control[CC_EXT_SUPERFRAME];
    // ------------------------------------------------------------
    // One-second timer
    // ------------------------------------------------------------
    logic [13:0] frame_count;
    logic [1:0] sec_phase;
    logic [13:0] sec_last;
    logic sec_event;
    // Two short seconds then one long keep the three-second total exact
    assign sec_last = (sec_phase == SEC_LAST_PHASE) ? 14'(SEC_LONG - 1) : 14'(SEC_SHORT - 1);
    assign sec_event = line_i.frame_tick && (frame_count == sec_last);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_count <= 14'h0000;
            sec_phase <= 2'h0;
        end else if (sec_event) begin
            frame_count <= 14'h0000;
            sec_phase <= (sec_phase == SEC_LAST_PHASE) ? 2'h0 : sec_phase + 2'h1;
        end else if (line_i.frame_tick) begin
            frame_count <= frame_count + 14'h0001;
        end
    end
    // ------------------------------------------------------------
    // Error accumulators and snapshots
    // ------------------------------------------------------------
    logic [15:0] bpv_acc;
    logic [15:0] crc_acc;
    logic [7:0] fe_acc;
    logic [15:0] bpv_snap;
    logic [15:0] crc_snap;
    logic [7:0] fe_snap;
    logic mf_errored;
    logic bpv_inc;
    logic crc_inc;
    logic fe_inc;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mf_errored <= 1'b0;
        end else if (line_i.mf_end) begin
            mf_errored <= 1'b0;
        end else if (line_i.crc_err || line_i.sync_lost) begin
            mf_errored <= 1'b1;
        end
    end

    always_comb begin
        if (second_receive_control[RC_ESF_EVENTS]) begin
            bpv_inc = line_i.mf_end && (mf_errored || line_i.crc_err || line_i.sync_lost);
        end else begin
            bpv_inc = line_i.bipolar_violation && !(second_common_control[CC_B8ZS] && line_i.b8zs_word);
        end
    end

    // CRC words only in extended mode with sync
    assign crc_inc = esf_mode && line_i.crc_err && !line_i.sync_lost;
    assign fe_inc = !line_i.sync_lost
        && (line_i.fbit_err || (!esf_mode && second_receive_control[RC_SIG_FRAMING_ERR] && line_i.sbit_err));
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bpv_acc <= 16'h0000;
            crc_acc <= 16'h0000;
            fe_acc <= 8'h00;
        end else if (sec_event) begin
            bpv_acc <= {15'h0000, bpv_inc};
            crc_acc <= {15'h0000, crc_inc};
            fe_acc <= {7'h00, fe_inc};
        end else begin
            if (bpv_inc && bpv_acc != SAT16) begin
                bpv_acc <= bpv_acc + 16'h0001;
            end
            if (crc_inc && crc_acc != SAT16) begin
                crc_acc <= crc_acc + 16'h0001;
            end
            if (fe_inc && fe_acc != SAT8) begin
                fe_acc <= fe_acc + 8'h01;
            end
        end
    end

    // Readable values cover the previous second
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bpv_snap <= 16'h0000;
            crc_snap <= 16'h0000;
            fe_snap <= 8'h00;
        end else if (sec_event) begin
            bpv_snap <= bpv_acc;
            crc_snap <= crc_acc;
            fe_snap <= fe_acc;
        end
    end

    // ------------------------------------------------------------
    // Receive data link
    // ------------------------------------------------------------
    logic [3:0] rx_ones;
    logic [7:0] rx_shift;
    logic [3:0] rx_count;
    logic [7:0] data_link_receive_byte;
    logic rx_drop;
    logic rx_take;
    logic rx_done;
    logic [7:0] next_rx_shift;
    logic rx_match;
    logic rx_abort;
    // Only a 0 after exactly five 1s is removed
    assign rx_drop = second_common_control[CC_DESTUFF] && !line_i.dl_bit && rx_ones == STUFF_RUN;
    assign rx_take = line_i.dl_valid && !rx_drop;
    // New bit enters at MSB so the first bit ends at LSB
    assign next_rx_shift = {line_i.dl_bit, rx_shift[7:1]};
    assign rx_done = rx_take && rx_count == BITS_PER_BYTE - 4'h1;
    // Compare the completed byte with both match bytes
    assign rx_match = rx_done
        && (next_rx_shift == data_link_match_byte_a || next_rx_shift == data_link_match_byte_b);
    // Eighth consecutive 1 flags an abort
    assign rx_abort = line_i.dl_valid && line_i.dl_bit && rx_ones == ABORT_RUN - 4'h1;

    // Run length saturates so long runs of 1s never look like five again
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_ones <= 4'h0;
        end else if (line_i.dl_valid) begin
            if (!line_i.dl_bit) begin
                rx_ones <= 4'h0;
            end else if (rx_ones != ABORT_RUN) begin
                rx_ones <= rx_ones + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_shift <= RST_BYTE;
            rx_count <= 4'h0;
            data_link_receive_byte <= RST_BYTE;
        end else if (rx_take) begin
            rx_shift <= next_rx_shift;
            rx_count <= rx_done ? 4'h0 : rx_count + 4'h1;
            // Unread bytes are overwritten; host has one byte time
            if (rx_done) begin
                data_link_receive_byte <= next_rx_shift;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit data link and output buffer
    // ------------------------------------------------------------
    logic [7:0] tx_shift;
    logic [3:0] tx_count;
    logic [3:0] tx_ones;
    logic tx_stuff_now;
    logic tx_push;
    logic tx_byte_done;
    logic [BUF_WIDTH-1:0] tx_push_bit;
    logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] buf_count;
    logic buf_full;
    logic buf_empty;
    logic buf_pop;
    assign buf_full = buf_count == (PW + 1)'(BUF_DEPTH);
    assign buf_empty = buf_count == '0;
    assign buf_pop = tx_bit_ready_i && !buf_empty;
    // Serializer stalls whenever the output buffer is full
    assign tx_push = !buf_full;
    assign tx_stuff_now = second_common_control[CC_STUFF] && tx_ones >= STUFF_RUN;
    assign tx_push_bit = tx_stuff_now ? '0 : BUF_WIDTH'(tx_shift[0]);
    assign tx_byte_done = tx_push && !tx_stuff_now && tx_count == BITS_PER_BYTE - 4'h1;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tx_shift <= RST_TX_BYTE;
            tx_count <= 4'h0;
            tx_ones <= 4'h0;
        end else if (tx_push) begin
            if (tx_stuff_now) begin
                tx_ones <= 4'h0;
            end else begin
                tx_ones <= tx_shift[0] ? tx_ones + 4'h1 : 4'h0;
                if (tx_byte_done) begin
                    tx_count <= 4'h0;
                    // Reloads the held byte, repeating it if unchanged
                    tx_shift <= wr_hit_tx ? host_i.wdata : data_link_transmit_byte;
                end else begin
                    tx_count <= tx_count + 4'h1;
                    tx_shift <= {1'b0, tx_shift[7:1]};
                end
            end
        end
    end

    // Two-entry buffer so a stalled framer loses no bit
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            buf_count <= '0;
        end else begin
            if (tx_push) begin
                wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (buf_pop) begin
                rd_ptr <= (rd_ptr == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
            buf_count <= buf_count + (PW + 1)'(tx_push) - (PW + 1)'(buf_pop);
        end
    end

    always_ff @(posedge clk_i) begin
        if (tx_push) begin
            buf_mem[wr_ptr] <= tx_push_bit;
        end
    end

    assign tx_bit_o = buf_empty ? '0 : buf_mem[rd_ptr];
    assign tx_bit_valid_o = !buf_empty;

    // ------------------------------------------------------------
    // Status register and interrupt
    // ------------------------------------------------------------
    logic rd_status;

    assign rd_status = host_i.rd && host_i.addr == OFF_SECOND_STATUS;

    always_comb begin
        status_set = 8'h00;
        status_set[ST_RX_MF] = line_i.mf_end;
        status_set[ST_TX_MF] = tx_mf_i;
        status_set[ST_SECOND] = sec_event;
        status_set[ST_RX_FULL] = rx_done;
        status_set[ST_TX_EMPTY] = tx_byte_done;
        status_set[ST_MATCH] = rx_match;
        status_set[ST_ABORT] = rx_abort;
        status_set[ST_LOSS_RX_CLK] = line_i.rx_clk_lost;
    end

    // Write of 1s arms the clear, the next read performs it
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            clear_pending <= 8'h00;
        end else if (host_i.wr && host_i.addr == OFF_SECOND_STATUS) begin
            clear_pending <= host_i.wdata;
        end else if (rd_status) begin
            clear_pending <= 8'h00;
        end
    end

    // Latching flags, a new event beats a clear
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            second_status_register <= 8'h00;
        end else begin
            second_status_register <= (second_status_register & ~(rd_status ? clear_pending : 8'h00))
                | status_set;
        end
    end

    // Unmasked flags pull the pin low
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            second_interrupt_output_b_o <= 1'b1;
        end else begin
            second_interrupt_output_b_o <= ~|(second_status_register & second_interrupt_mask);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped offsets read as zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (host_i.rd) begin
            unique case (host_i.addr)
                OFF_SECOND_STATUS: rdata_o <= second_status_register;
                OFF_BPV_HIGH: rdata_o <= bpv_snap[15:8];
                OFF_BPV_LOW: rdata_o <= bpv_snap[7:0];
                OFF_CRC_HIGH: rdata_o <= crc_snap[15:8];
                OFF_CRC_LOW: rdata_o <= crc_snap[7:0];
                OFF_FBIT_ERR: rdata_o <= fe_snap;
                OFF_DL_RX_BYTE: rdata_o <= data_link_receive_byte;
                OFF_DL_MATCH_A: rdata_o <= data_link_match_byte_a;
                OFF_DL_MATCH_B: rdata_o <= data_link_match_byte_b;
                OFF_COMMON_CTRL: rdata_o <= second_common_control;
                OFF_RX_CTRL: rdata_o <= second_receive_control;
                OFF_SECOND_MASK: rdata_o <= second_interrupt_mask;
                OFF_DL_TX_BYTE: rdata_o <= data_link_transmit_byte;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

endmodule

/* File: tb/t1_maint_checker.sv */
// Port checker for the T1 maintenance block
`timescale 1ns/10ps
module t1_maint_checker
import t1_maint_pkg::*;
#(
    parameter int BUF_WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire t1_maint_pkg::host_req_t host_i,
    input wire logic [7:0] rdata_o,
    input wire t1_maint_pkg::line_rx_t line_i,
    input wire logic tx_mf_i,
    input wire logic [BUF_WIDTH-1:0] tx_bit_o,
    input wire logic tx_bit_valid_o,
    input wire logic tx_bit_ready_i,
    input wire logic second_interrupt_output_b_o
);
    // ----------------
    // Shadow registers
    // ----------------
    logic [7:0] mask;
    logic [7:0] txb;
    logic stuff;
    logic [2:0] ones;
    wire pop = tx_bit_valid_o && tx_bit_ready_i;
    wire wr_ctrl = host_i.wr && host_i.addr == OFF_COMMON_CTRL;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mask <= RST_MASK;
            txb <= RST_TX_BYTE;
            stuff <= 1'b0;
        end else if (host_i.wr) begin
            if (host_i.addr == OFF_SECOND_MASK) mask <= host_i.wdata;
            if (host_i.addr == OFF_DL_TX_BYTE) txb <= host_i.wdata;
            if (wr_ctrl) stuff <= host_i.wdata[CC_STUFF];
        end
    end
    // Run restarts at a control write, earlier history is unknown
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || wr_ctrl) begin
            ones <= 3'h0;
        end else if (pop) begin
            ones <= tx_bit_o[0] ? ones + 3'h1 : 3'h0;
        end
    end
    // ----------
    // Assertions
    // ----------
    tx_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_bit_valid_o && !tx_bit_ready_i |=> tx_bit_valid_o && $stable(tx_bit_o))
        else $error("bit moved in stall");
    tx_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !tx_bit_valid_o |-> tx_bit_o == '0) else $error("idle bit not 0");
    rd_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !host_i.rd |=> $stable(rdata_o)) else $error("read data moved");
    int_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(mask) == 8'h00 |-> second_interrupt_output_b_o) else $error("masked int low");
    stuff_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        stuff && pop && ones == 3'h5 |-> !tx_bit_o[0]) else $error("no stuffed 0");
    txb_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        host_i.rd && !host_i.wr && host_i.addr == OFF_DL_TX_BYTE |=> rdata_o == txb)
        else $error("tx byte readback");
    mask_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        host_i.rd && !host_i.wr && host_i.addr == OFF_SECOND_MASK |=> rdata_o == mask)
        else $error("mask readback");
    start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> second_interrupt_output_b_o ##2 tx_bit_valid_o)
        else $error("bad start");
endmodule
bind t1_perf_counters_fdl_link t1_maint_checker #(.BUF_WIDTH(BUF_WIDTH)) chk_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .host_i(host_i), .rdata_o(rdata_o),
    .line_i(line_i), .tx_mf_i(tx_mf_i), .tx_bit_o(tx_bit_o), .tx_bit_valid_o(tx_bit_valid_o),
    .tx_bit_ready_i(tx_bit_ready_i), .second_interrupt_output_b_o(second_interrupt_output_b_o));

/* File: tb/t1_tx_sink.sv */
// Framer-side sink taking transmit link bits
`timescale 1ns/10ps
module t1_tx_sink (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic bit_i,
    input wire logic valid_i,
    input wire logic slow_i,
    output logic ready_o
);
    logic ph;
    logic got[$];
    // Slow mode stalls every other cycle
    assign ready_o = !(slow_i && ph);
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ph <= 1'b0;
        end else begin
            ph <= !ph;
            if (valid_i && ready_o) got.push_back(bit_i);
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the T1 maintenance block
`timescale 1ns/10ps
module tb_top;
    import t1_maint_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    host_req_t host_i = '0;
    line_rx_t line_i = '0;
    logic slow = 1'b0;
    logic ready;
    logic valid;
    logic [0:0] tbit;
    logic [7:0] rdata;
    logic [7:0] v;
    logic int_b;
    int fails = 0;
    int n_checks = 0;
    always #25 clk_i = !clk_i;
    // Short seconds keep three intervals within a brief run
    t1_perf_counters_fdl_link #(.SEC_SHORT(4), .SEC_LONG(6)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .host_i(host_i), .rdata_o(rdata),
        .line_i(line_i), .tx_mf_i(1'b0), .tx_bit_o(tbit), .tx_bit_valid_o(valid),
        .tx_bit_ready_i(ready), .second_interrupt_output_b_o(int_b));
    t1_tx_sink sink (.clk_i(clk_i), .rst_b_i(rst_b_i), .bit_i(tbit[0]), .valid_i(valid),
        .slow_i(slow), .ready_o(ready));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_i <= '{1'b1, 1'b0, a, d};
        @(negedge clk_i);
        host_i <= '0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a);
        host_i <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i);
        host_i <= '0;
        @(negedge clk_i);
        v = rdata;
    endtask
    task automatic lp(input logic [10:0] s, input int n);
        repeat (n) begin
            line_i <= s;
            @(negedge clk_i);
            line_i <= '0;
            @(negedge clk_i);
        end
    endtask
    task automatic dl(input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            lp({8'h00, 1'b1, b[i], 1'b0}, 1);
        end
    endtask
    task automatic sec(input int et, input logic [15:0] eb, ec, input logic [7:0] ef);
        int t;
        logic [7:0] e[5];
        e = '{eb[15:8], eb[7:0], ec[15:8], ec[7:0], ef};
        t = 0;
        v = 8'h00;
        while (!v[ST_SECOND] && t < 10) begin
            lp(11'h008, 1);
            t++;
            rd(OFF_SECOND_STATUS);
        end
        chk(8'(t), 8'(et));
        wr(OFF_SECOND_STATUS, 8'h20);
        rd(OFF_SECOND_STATUS);
        for (int i = 0; i < 5; i++) begin
            rd(OFF_BPV_HIGH + 8'(i));
            chk(v, e[i]);
        end
    endtask
    task automatic test_regs;
        rd(OFF_DL_TX_BYTE);
        chk(v, 8'hff);
        rd(OFF_SECOND_MASK);
        chk(v, 8'h00);
        wr(OFF_BPV_HIGH, 8'h55);
        rd(OFF_BPV_HIGH);
        chk(v, 8'h00);
        wr(OFF_DL_MATCH_B, 8'ha5);
        rd(OFF_DL_MATCH_B);
        chk(v, 8'ha5);
        $display("test_regs done");
    endtask
    task automatic test_counters;
        wr(OFF_COMMON_CTRL, 8'h08);
        lp(11'h200, 2);
        lp(11'h600, 1);
        lp(11'h080, 1);
        lp(11'h480, 1);
        lp(11'h040, 300);
        sec(4, 16'h0003, 16'h0001, 8'hff);
        wr(OFF_COMMON_CTRL, 8'h0c);
        lp(11'h300, 2);
        lp(11'h200, 1);
        lp(11'h440, 2);
        lp(11'h040, 1);
        sec(4, 16'h0001, 16'h0000, 8'h01);
        wr(OFF_COMMON_CTRL, 8'h00);
        wr(OFF_RX_CTRL, 8'h03);
        lp(11'h080, 1);
        lp(11'h010, 2);
        lp(11'h040, 1);
        lp(11'h020, 1);
        sec(6, 16'h0001, 16'h0000, 8'h02);
        wr(OFF_RX_CTRL, 8'h00);
        $display("test_counters done");
    endtask
    task automatic test_rx;
        wr(OFF_SECOND_MASK, 8'h14);
        wr(OFF_DL_MATCH_A, 8'h01);
        dl(16'h0001, 8);
        chk({7'h00, int_b}, 8'h00);
        rd(OFF_DL_RX_BYTE);
        chk(v, 8'h01);
        rd(OFF_SECOND_STATUS);
        chk(v & 8'h14, 8'h14);
        wr(OFF_COMMON_CTRL, 8'h01);
        dl(16'h00df, 9);
        rd(OFF_DL_RX_BYTE);
        chk(v, 8'h7f);
        dl(16'h003f, 8);
        rd(OFF_DL_RX_BYTE);
        chk(v, 8'h3f);
        dl(16'h00ff, 8);
        rd(OFF_SECOND_STATUS);
        chk(v & 8'h02, 8'h02);
        wr(OFF_SECOND_STATUS, 8'h16);
        rd(OFF_SECOND_STATUS);
        rd(OFF_SECOND_STATUS);
        chk(v & 8'h16, 8'h00);
        chk({7'h00, int_b}, 8'h01);
        $display("test_rx done");
    endtask
    task automatic test_tx;
        int k;
        logic [15:0] w;
        slow = 1'b1;
        wr(OFF_DL_TX_BYTE, 8'h00);
        repeat (60) @(negedge clk_i);
        wr(OFF_COMMON_CTRL, 8'h10);
        sink.got.delete();
        wr(OFF_DL_TX_BYTE, 8'h1f);
        wr(OFF_SECOND_STATUS, 8'h08);
        rd(OFF_SECOND_STATUS);
        repeat (90) @(negedge clk_i);
        k = 0;
        while (k < 40 && sink.got[k] !== 1'b1) k++;
        for (int i = 0; i < 16; i++) w[i] = sink.got[k + i];
        chk(w[7:0], 8'h1f);
        chk({2'h0, w[13:8]}, 8'h3e);
        rd(OFF_SECOND_STATUS);
        chk(v & 8'h08, 8'h08);
        $display("test_tx done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("MISMATCH %0t watchdog expired", $time);
        give_verdict;
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        test_regs;
        test_counters;
        test_rx;
        test_tx;
        give_verdict;
    end
endmodule
